//--- design/rst_seq_pkg.sv
// Purpose: Shared constants for the system reset sequencer.
// Assumes: One system clock, ref_clk, at 125 MHz.
// Notes: Counts are in system clock cycles.
package rst_seq_pkg;
  localparam int HOLD_CYCLES = 1025;
  localparam int HOLD_W = 11;
  localparam logic [HOLD_W-1:0] HOLD_TERM = 11'(HOLD_CYCLES - 1);
  localparam int PIN_LOW_SAMPLES = 3;
  localparam int PIN_HIGH_SAMPLES = 4;
  localparam int QUAL_W = 3;
  localparam logic [1:0] CLK_SRC_CRYSTAL = 2'h0;
  localparam logic [23:0] PROGRAM_COUNTER_RESET = 24'h000000;
  typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_COUNT, ST_WAIT} seq_state_t;
endpackage : rst_seq_pkg

//--- design/consec_qualifier.sv
// Purpose: Flags a synchronised level held for a number of consecutive samples.
// Assumes: The sample input is already in the ref_clk domain.
// Notes: The flag stays set while the level persists.
module consec_qualifier #(
  parameter int COUNT = 3,
  parameter int CNT_W = 3,
  parameter logic LEVEL = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic sample,
  output logic hit
);
  localparam logic [CNT_W-1:0] TARGET = CNT_W'(COUNT);
  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (sample != LEVEL) begin
      cnt_r <= '0;
    end else if (cnt_r != TARGET) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign hit = (cnt_r == TARGET);
endmodule : consec_qualifier

//--- design/system_reset_sequencer.sv
// Purpose: Central reset controller gathering six reset sources.
// Assumes: por_req and brownout_req come from analog detectors, asynchronous.
// Notes: The reset pin is open drain; the pad resolves its level.
module system_reset_sequencer
  import rst_seq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic por_req,
  input wire logic brownout_req,
  input wire logic watchdog_timer_req,
  input wire logic rtc_alarm_req,
  input wire logic sleep_active,
  input wire logic debug_reset_req,
  input wire logic [1:0] clock_source_req,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic sys_reset_b,
  output logic cpu_run,
  output logic gpio_input_force,
  output logic program_counter_clear,
  output logic [23:0] program_counter_init,
  output logic [1:0] clock_source_select
);
  seq_state_t state_r, state_nxt;
  logic [HOLD_W-1:0] hold_cnt_r;
  logic [1:0] analog_meta_r, analog_sync_r;
  logic pin_meta_r, pin_sync_r;
  logic pin_low_hit, pin_high_hit;
  logic req_any;
  logic reset_pin_out_r, reset_pin_oe_r, sys_reset_b_r, cpu_run_r;
  logic gpio_input_force_r, program_counter_clear_r;
  logic [23:0] program_counter_init_r;
  logic [1:0] clock_source_select_r;
  logic [HOLD_W:0] check_len_r;

  // Analog detector requests are brought onto the system clock.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      analog_meta_r <= 2'h0;
      analog_sync_r <= 2'h0;
    end else begin
      analog_meta_r <= {brownout_req, por_req};
      analog_sync_r <= analog_meta_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta_r <= 1'b1;
      pin_sync_r <= 1'b1;
    end else begin
      pin_meta_r <= reset_pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  consec_qualifier #(
    .COUNT(PIN_LOW_SAMPLES),
    .CNT_W(QUAL_W),
    .LEVEL(1'b0)
  ) u_low_qual (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sample(pin_sync_r),
    .hit(pin_low_hit)
  );

  consec_qualifier #(
    .COUNT(PIN_HIGH_SAMPLES),
    .CNT_W(QUAL_W),
    .LEVEL(1'b1)
  ) u_high_qual (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sample(pin_sync_r),
    .hit(pin_high_hit)
  );

  assign req_any = analog_sync_r[0] | analog_sync_r[1] | watchdog_timer_req |
                   (rtc_alarm_req & sleep_active) | debug_reset_req;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (req_any) begin
          state_nxt = ST_HOLD;
        end else if (pin_low_hit) begin
          state_nxt = ST_COUNT;
        end
      end
      ST_HOLD: begin
        if (!req_any) begin
          state_nxt = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (req_any) begin
          state_nxt = ST_HOLD;
        end else if (hold_cnt_r == HOLD_TERM) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (req_any) begin
          state_nxt = ST_HOLD;
        end else if (pin_high_hit) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_HOLD;
      end
    endcase
  end

  // Power-up of this logic counts as a reset event.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_COUNT;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_cnt_r <= '0;
    end else if (state_nxt == ST_COUNT && state_r == ST_COUNT) begin
      hold_cnt_r <= hold_cnt_r + 1'b1;
    end else begin
      hold_cnt_r <= '0;
    end
  end

  // drive pin low, release at terminal count.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reset_pin_oe_r <= 1'b1;
      reset_pin_out_r <= 1'b0;
    end else begin
      reset_pin_oe_r <= (state_nxt == ST_HOLD) || (state_nxt == ST_COUNT);
      reset_pin_out_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_reset_b_r <= 1'b0;
      cpu_run_r <= 1'b0;
    end else begin
      sys_reset_b_r <= (state_nxt == ST_RUN);
      cpu_run_r <= (state_nxt == ST_RUN);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      gpio_input_force_r <= 1'b1;
      program_counter_clear_r <= 1'b1;
      program_counter_init_r <= PROGRAM_COUNTER_RESET;
    end else begin
      gpio_input_force_r <= (state_nxt != ST_RUN);
      program_counter_clear_r <= (state_nxt != ST_RUN);
      program_counter_init_r <= PROGRAM_COUNTER_RESET;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      clock_source_select_r <= CLK_SRC_CRYSTAL;
    end else if (state_nxt != ST_RUN) begin
      clock_source_select_r <= CLK_SRC_CRYSTAL;
    end else begin
      clock_source_select_r <= clock_source_req;
    end
  end

  assign reset_pin_out = reset_pin_out_r;
  assign reset_pin_oe = reset_pin_oe_r;
  assign sys_reset_b = sys_reset_b_r;
  assign cpu_run = cpu_run_r;
  assign gpio_input_force = gpio_input_force_r;
  assign program_counter_clear = program_counter_clear_r;
  assign program_counter_init = program_counter_init_r;
  assign clock_source_select = clock_source_select_r;

  // Independent length of the current counting run, for checking only.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      check_len_r <= '0;
    end else if (state_r == ST_COUNT) begin
      check_len_r <= check_len_r + 1'b1;
    end else begin
      check_len_r <= '0;
    end
  end

  property p_run_only_out_of_reset;
    @(posedge ref_clk) disable iff (!rst_b)
      (state_r != ST_RUN) |-> (!sys_reset_b_r && !cpu_run_r);
  endproperty
  a_run_only_out_of_reset: assert property (p_run_only_out_of_reset)
    else $error("Chip left reset while sequencer not running.");
  property p_ports_input_in_reset;
    @(posedge ref_clk) disable iff (!rst_b)
      !cpu_run_r |-> (gpio_input_force_r && program_counter_clear_r &&
                      program_counter_init_r == PROGRAM_COUNTER_RESET);
  endproperty
  a_ports_input_in_reset: assert property (p_ports_input_in_reset)
    else $error("Ports or program counter not forced during reset.");
  property p_no_run_with_request;
    @(posedge ref_clk) disable iff (!rst_b)
      req_any |=> !cpu_run_r ##1 !cpu_run_r;
  endproperty
  a_no_run_with_request: assert property (p_no_run_with_request)
    else $error("Execution ran right after a reset request.");
  property p_rtc_needs_sleep;
    @(posedge ref_clk) disable iff (!rst_b)
      (state_r == ST_RUN && rtc_alarm_req && !sleep_active && !watchdog_timer_req &&
       !debug_reset_req && analog_sync_r == 2'h0 && !pin_low_hit) |=> state_r == ST_RUN;
  endproperty
  a_rtc_needs_sleep: assert property (p_rtc_needs_sleep)
    else $error("Alarm reset taken while awake.");
  property p_hold_length;
    @(posedge ref_clk) disable iff (!rst_b)
      (state_r == ST_COUNT && state_nxt == ST_WAIT) |-> check_len_r == 12'(HOLD_CYCLES - 1);
  endproperty
  a_hold_length: assert property (p_hold_length)
    else $error("Reset hold was not 1025 cycles.");
  property p_count_after_release;
    @(posedge ref_clk) disable iff (!rst_b)
      (state_r == ST_HOLD && !req_any) |=> (state_r == ST_COUNT && hold_cnt_r == '0);
  endproperty
  a_count_after_release: assert property (p_count_after_release)
    else $error("Timer did not start after request release.");
  property p_pin_low_starts;
    @(posedge ref_clk) disable iff (!rst_b)
      (state_r == ST_RUN && !req_any && !pin_sync_r && $past(!pin_sync_r, 1) &&
       $past(!pin_sync_r, 2) && $past(!pin_sync_r, 3)) |=> (state_r == ST_COUNT && reset_pin_oe_r);
  endproperty
  a_pin_low_starts: assert property (p_pin_low_starts)
    else $error("Qualified low pin did not start the timer.");
  property p_crystal_in_reset;
    @(posedge ref_clk) disable iff (!rst_b)
      !sys_reset_b_r |-> clock_source_select_r == CLK_SRC_CRYSTAL;
  endproperty
  a_crystal_in_reset: assert property (p_crystal_in_reset)
    else $error("Clock source not crystal during reset.");
  property p_drive_on_event;
    @(posedge ref_clk) disable iff (!rst_b)
      req_any |=> (reset_pin_oe_r && !reset_pin_out_r);
  endproperty
  a_drive_on_event: assert property (p_drive_on_event)
    else $error("Reset pin not driven low after a request.");
  property p_release_at_terminal;
    @(posedge ref_clk) disable iff (!rst_b)
      $fell(reset_pin_oe_r) |-> ($past(state_r) == ST_COUNT && $past(hold_cnt_r) == HOLD_TERM);
  endproperty
  a_release_at_terminal: assert property (p_release_at_terminal)
    else $error("Reset pin released away from terminal count.");
  // Four high pin samples while waiting must start execution within two cycles, unless a request moves to hold.
  property p_run_after_timeout;
    @(posedge ref_clk) disable iff (!rst_b)
      (state_r == ST_WAIT && !req_any && pin_sync_r && $past(pin_sync_r, 1) &&
       $past(pin_sync_r, 2) && $past(pin_sync_r, 3)) |->
      ##[1:2] (cpu_run_r || state_r == ST_HOLD);
  endproperty
  a_run_after_timeout: assert property (p_run_after_timeout)
    else $error("Execution did not begin after released pin.");
  property p_wait_for_high;
    @(posedge ref_clk) disable iff (!rst_b)
      $rose(cpu_run_r) |-> ($past(pin_sync_r, 2) && $past(pin_sync_r, 3) &&
                             $past(pin_sync_r, 4) && $past(pin_sync_r, 5));
  endproperty
  a_wait_for_high: assert property (p_wait_for_high)
    else $error("Execution began without four high pin samples.");
  property p_pin_sync_path;
    @(posedge ref_clk) disable iff (!rst_b)
      ##1 pin_sync_r == $past(pin_meta_r);
  endproperty
  a_pin_sync_path: assert property (p_pin_sync_path)
    else $error("Pin synchroniser second stage mismatch.");
endmodule : system_reset_sequencer

//--- test/reset_pin_driver.sv
// Purpose: Open-drain reset pad with a pull-up and an outside reset driver.
// Assumes: No party drives the pad high; released, the pull-up wins.
// Notes: hold_low is the supervisor output, set by the bench.
module reset_pin_driver (
  input wire logic dev_out,
  input wire logic dev_oe,
  input wire logic hold_low,
  output logic pad
);
  timeunit 1ns;
  timeprecision 100ps;
  assign pad = ((dev_oe && !dev_out) || hold_low) ? 1'b0 : 1'b1;
endmodule : reset_pin_driver

//--- test/system_reset_sequencer_tb.sv
// Purpose: Self-checking bench for the system reset sequencer.
// Assumes: Inputs change on the falling edge of ref_clk.
// Notes: The full 1025-cycle hold is used, so each reset takes a while.
module system_reset_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import rst_seq_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  // Bits: power-on, brownout, watchdog, alarm, debug.
  logic [4:0] req = 5'h00;
  logic sleep_active = 1'b0;
  logic [1:0] clock_source_req = 2'h2;
  logic hold_low = 1'b0;
  logic pad, pin_out, pin_oe, sys_reset_b, cpu_run, gpio_force, counter_clear;
  logic [23:0] counter_init;
  logic [1:0] clk_sel;
  int errors = 0;
  int checked = 0;

  system_reset_sequencer i_system_reset_sequencer (
    .ref_clk(ref_clk), .rst_b(rst_b), .por_req(req[0]), .brownout_req(req[1]),
    .watchdog_timer_req(req[2]), .rtc_alarm_req(req[3]), .sleep_active(sleep_active),
    .debug_reset_req(req[4]), .clock_source_req(clock_source_req),
    .reset_pin_in(pad), .reset_pin_out(pin_out), .reset_pin_oe(pin_oe),
    .sys_reset_b(sys_reset_b), .cpu_run(cpu_run), .gpio_input_force(gpio_force),
    .program_counter_clear(counter_clear), .program_counter_init(counter_init),
    .clock_source_select(clk_sel)
  );

  reset_pin_driver i_reset_pin_driver (
    .dev_out(pin_out), .dev_oe(pin_oe), .hold_low(hold_low), .pad(pad)
  );

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  task automatic cycles(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cycles

  task automatic wait_run(input int n);
    int k;
    k = 0;
    while (cpu_run !== 1'b1 && k < n) begin
      @(negedge ref_clk);
      k++;
    end
    if (cpu_run !== 1'b1) begin
      check(cpu_run, 24'h000001);
      conclude();
    end
  endtask : wait_run

  task automatic check_held();
    check(pin_oe, 24'h000001);
    check(pin_out, 24'h000000);
    check(sys_reset_b, 24'h000000);
    check(cpu_run, 24'h000000);
    check(gpio_force, 24'h000001);
    check(counter_clear, 24'h000001);
    check(counter_init, 24'h000000);
    check(clk_sel, 24'(CLK_SRC_CRYSTAL));
  endtask : check_held

  task automatic timer_check();
    cycles(1024);
    check(pin_oe, 24'h000001);
    cycles(8);
    check(pin_oe, 24'h000000);
    wait_run(20);
    check(sys_reset_b, 24'h000001);
    check(gpio_force, 24'h000000);
    check(counter_clear, 24'h000000);
  endtask : timer_check

  task automatic t_power();
    cycles(19);
    check_held();
    cycles(1);
    rst_b = 1'b1;
    timer_check();
    cycles(2);
    check(clk_sel, 24'h000002);
    $display("t_power done");
  endtask : t_power

  task automatic t_refused();
    req[3] = 1'b1;
    cycles(20);
    check(pin_oe, 24'h000000);
    check(cpu_run, 24'h000001);
    req[3] = 1'b0;
    $display("t_refused done");
  endtask : t_refused

  task automatic t_sources();
    for (int i = 0; i < 5; i++) begin
      sleep_active = (i == 3);
      req[i] = 1'b1;
      cycles(4);
      check_held();
      cycles(1100);
      req[i] = 1'b0;
      timer_check();
      sleep_active = 1'b0;
    end
    $display("t_sources done");
  endtask : t_sources

  task automatic t_pin_early();
    hold_low = 1'b1;
    cycles(2);
    hold_low = 1'b0;
    cycles(10);
    check(cpu_run, 24'h000001);
    hold_low = 1'b1;
    cycles(3);
    check(pin_oe, 24'h000000);
    cycles(7);
    check_held();
    hold_low = 1'b0;
    cycles(1015);
    check(pin_oe, 24'h000001);
    cycles(12);
    check(pin_oe, 24'h000000);
    wait_run(20);
    $display("t_pin_early done");
  endtask : t_pin_early

  task automatic t_pin_late();
    hold_low = 1'b1;
    cycles(1100);
    check(pin_oe, 24'h000000);
    check(cpu_run, 24'h000000);
    hold_low = 1'b0;
    cycles(4);
    check(cpu_run, 24'h000000);
    wait_run(12);
    $display("t_pin_late done");
  endtask : t_pin_late

  initial begin
    t_power();
    t_refused();
    t_sources();
    t_pin_early();
    t_pin_late();
    conclude();
  end
endmodule : system_reset_sequencer_tb
